// File: rtl/scmc_clock_mode.v
// System clock selection and operating-mode control.
// Assumes the CPU core drives halt_req as a one-cycle pulse on sys_clk,
// and oscillator ticks arrive from outside and are synchronised here.
// Oscillator start-up and stability delays are not modelled.
`timescale 1ns/1ns
`include "scmc_map.vh"

// Contract
// - Low-speed clock comes from external crystal or internal RC per ls_source_select.
// - System clock is high-speed (maybe divided) or low-speed per sys_clk_select.
// - High-speed clock comes from external crystal or internal RC per hs_source_select.
// - Divided high-speed clocks from one half to one sixty-fourth are offered.
// - In slow mode high-speed oscillator runs or stops by its enable bit.
// - Six modes: fast, slow, sleep, halt_ls_only, halt_both_osc, halt_hs_only.
// - Fast mode, select 000-110: high-speed divided, all clocks running.
// - Slow mode, select 111: CPU on low-speed clock, high-speed per enable.
// - Halt with both keep bits low enters sleep, stopping everything but the internal low-speed RC while watchdog is enabled.
// - In sleep internal low-speed RC runs only when watchdog is enabled.
// - Halt, keeps 0/1: halt_ls_only; system clock only when select is 111.
// - Halt, both keeps high: halt_both_osc; all clocks run, CPU stops.
// - Halt, keeps 1/0: halt_hs_only; system clock only when select 000-110.
// - Select 000 undivided, 001-110 divide by 2..64, 111 low-speed.
// - Source select 0 is internal RC, 1 is external crystal.
// - Both keep-alive bits reset to zero; 1 keeps oscillator in halt.
module scmc_clock_mode (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control writes from the CPU core
  input wire ctrl_we,
  input wire [`SCMC_SEL_W-1:0] ctrl_sys_clk_select,
  input wire ctrl_hs_source_select,
  input wire ctrl_ls_source_select,
  input wire ctrl_hs_osc_keep_in_halt,
  input wire ctrl_ls_osc_keep_in_halt,
  input wire hs_osc_enable,
  input wire watchdog_enable,
  // Halt and wake
  input wire halt_req,
  input wire wake_req,
  // Oscillator ticks, asynchronous to sys_clk
  input wire ext_high_speed_crystal,
  input wire int_high_speed_rc,
  input wire ext_low_speed_crystal,
  input wire int_low_speed_rc,
  // Current settings
  output reg [`SCMC_SEL_W-1:0] sys_clk_select,
  output reg hs_source_select,
  output reg ls_source_select,
  output reg hs_osc_keep_in_halt,
  output reg ls_osc_keep_in_halt,
  // Mode and clock enables
  output reg [`SCMC_MODE_W-1:0] mode,
  output reg cpu_run,
  output reg hs_osc_on,
  output reg ls_osc_on,
  output reg int_ls_rc_on,
  output reg sys_clk_on,
  output reg high_speed_clock,
  output reg low_speed_clock,
  output reg sys_clk_tick
);

  localparam [5:0] ST_FAST = `SCMC_MODE_FAST;
  localparam [5:0] ST_SLOW = `SCMC_MODE_SLOW;
  localparam [5:0] ST_SLEEP = `SCMC_MODE_SLEEP;
  localparam [5:0] ST_HALT_LS = `SCMC_MODE_HALT_LS;
  localparam [5:0] ST_HALT_BOTH = `SCMC_MODE_HALT_BOTH;
  localparam [5:0] ST_HALT_HS = `SCMC_MODE_HALT_HS;

  reg [5:0] next_mode;
  reg next_hs_on;
  reg next_ls_on;
  reg next_int_ls_rc_on;
  reg next_sys_on;
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] sync3;
  wire [3:0] osc_in;
  wire [3:0] osc_edge;
  wire hs_edge;
  wire ls_edge;
  wire div_tick;
  wire halt_take;
  wire wake_take;
  wire write_take;
  wire sys_src_edge;

  // Decoding used for both run and halt choices
  function is_ls_sel;
    input [`SCMC_SEL_W-1:0] sel;
    begin
      is_ls_sel = (sel == `SCMC_SEL_LS);
    end
  endfunction

  // Stopped mode chosen by the keep bits sampled with the halt
  function [5:0] halt_target;
    input hs_keep;
    input ls_keep;
    begin
      case ({hs_keep, ls_keep})
        2'b00: halt_target = ST_SLEEP;
        2'b01: halt_target = ST_HALT_LS;
        2'b11: halt_target = ST_HALT_BOTH;
        default: halt_target = ST_HALT_HS;
      endcase
    end
  endfunction

  // Fast and slow are the only modes in which the CPU runs
  function is_run_mode;
    input [5:0] m;
    begin
      is_run_mode = (m == ST_FAST) || (m == ST_SLOW);
    end
  endfunction

  // ------------------------------------------------------------
  // Request qualification
  // ------------------------------------------------------------
  // A stopped CPU issues no writes or halts, so stray strobes are dropped;
  // a wake only matters while the CPU is stopped
  assign write_take = ctrl_we & cpu_run;
  assign halt_take = halt_req & cpu_run;
  assign wake_take = wake_req & ~cpu_run;

  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sys_clk_select <= `SCMC_SEL_RESET;
      hs_source_select <= `SCMC_SRC_INT;
      ls_source_select <= `SCMC_SRC_INT;
      hs_osc_keep_in_halt <= `SCMC_KEEP_RESET;
      ls_osc_keep_in_halt <= `SCMC_KEEP_RESET;
    end else if (write_take) begin
      sys_clk_select <= ctrl_sys_clk_select;
      hs_source_select <= ctrl_hs_source_select;
      ls_source_select <= ctrl_ls_source_select;
      hs_osc_keep_in_halt <= ctrl_hs_osc_keep_in_halt;
      ls_osc_keep_in_halt <= ctrl_ls_osc_keep_in_halt;
    end
  end

  // ------------------------------------------------------------
  // Oscillator synchronisers
  // ------------------------------------------------------------
  // Order: hs crystal, hs rc, ls crystal, ls rc
  assign osc_in = {int_low_speed_rc, ext_low_speed_crystal,
                   int_high_speed_rc, ext_high_speed_crystal};

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else begin
      sync1 <= osc_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge detect reads only the second and third stages
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_edge
      assign osc_edge[g] = sync2[g] & ~sync3[g];
    end
  endgenerate

  // Source muxes, gated by oscillator enables
  assign hs_edge = hs_osc_on &
                   (hs_source_select == `SCMC_SRC_EXT ? osc_edge[0] : osc_edge[1]);
  assign ls_edge = ls_osc_on &
                   (ls_source_select == `SCMC_SRC_EXT ? osc_edge[2] : osc_edge[3]);

  // Divider sees only qualified high-speed edges
  scmc_divider u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(hs_edge),
    .sel(sys_clk_select),
    .tick(div_tick)
  );

  // ------------------------------------------------------------
  // System tick source
  // ------------------------------------------------------------
  // The divider steps once per selected high-speed edge, so the ratio
  // is exact; a tick lags its high-speed edge by one cycle
  assign sys_src_edge = is_ls_sel(sys_clk_select) ? ls_edge : div_tick;

  // ------------------------------------------------------------
  // Mode machine
  // ------------------------------------------------------------
  always @* begin
    next_mode = mode;
    case (mode)
      ST_FAST, ST_SLOW: begin
        if (halt_take) begin
          next_mode = halt_target(hs_osc_keep_in_halt, ls_osc_keep_in_halt);
        end else if (is_ls_sel(sys_clk_select)) begin
          next_mode = ST_SLOW;
        end else begin
          next_mode = ST_FAST;
        end
      end
      ST_SLEEP, ST_HALT_LS, ST_HALT_BOTH, ST_HALT_HS: begin
        if (wake_take)
          next_mode = is_ls_sel(sys_clk_select) ? ST_SLOW : ST_FAST;
      end
      default: next_mode = ST_FAST;
    endcase
  end

  // Clock enables per mode
  always @* begin
    next_hs_on = 1'b0;
    next_ls_on = 1'b0;
    next_int_ls_rc_on = 1'b1;
    next_sys_on = 1'b0;
    case (next_mode)
      ST_FAST: begin
        next_hs_on = 1'b1;
        next_ls_on = 1'b1;
        next_sys_on = 1'b1;
      end
      ST_SLOW: begin
        next_hs_on = hs_osc_enable;
        next_ls_on = 1'b1;
        next_sys_on = 1'b1;
      end
      ST_SLEEP: begin
        next_int_ls_rc_on = watchdog_enable;
      end
      ST_HALT_LS: begin
        next_ls_on = 1'b1;
        next_sys_on = is_ls_sel(sys_clk_select);
      end
      ST_HALT_BOTH: begin
        next_hs_on = 1'b1;
        next_ls_on = 1'b1;
        next_sys_on = 1'b1;
      end
      ST_HALT_HS: begin
        next_hs_on = 1'b1;
        next_sys_on = !is_ls_sel(sys_clk_select);
      end
      default: begin
        next_hs_on = 1'b1;
        next_ls_on = 1'b1;
        next_sys_on = 1'b1;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      mode <= ST_FAST;
      cpu_run <= 1'b1;
    end else begin
      mode <= next_mode;
      cpu_run <= is_run_mode(next_mode);
    end
  end

  // Enables are registered from the next mode so they switch with it
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      hs_osc_on <= 1'b1;
      ls_osc_on <= 1'b1;
      int_ls_rc_on <= 1'b1;
      sys_clk_on <= 1'b1;
    end else begin
      hs_osc_on <= next_hs_on;
      ls_osc_on <= next_ls_on;
      int_ls_rc_on <= next_int_ls_rc_on;
      sys_clk_on <= next_sys_on;
    end
  end

  // ------------------------------------------------------------
  // Clock tick outputs
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      high_speed_clock <= 1'b0;
      low_speed_clock <= 1'b0;
      sys_clk_tick <= 1'b0;
    end else begin
      high_speed_clock <= hs_edge;
      low_speed_clock <= ls_edge;
      sys_clk_tick <= sys_clk_on & sys_src_edge;
    end
  end

endmodule // scmc_clock_mode

// File: rtl/scmc_divider.v
// Divider for the high-speed clock: produces enables at 1/1 .. 1/64.
// Assumes it runs on sys_clk and counts one tick per high-speed edge.
`timescale 1ns/1ns
`include "scmc_map.vh"

module scmc_divider (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Control
  input wire run,
  input wire [`SCMC_SEL_W-1:0] sel,
  // Divided enable
  output reg tick
);

  reg [`SCMC_DIV_W-1:0] count;
  reg hit;
  integer i;

  // ------------------------------------------------------------
  // Tap decode
  // ------------------------------------------------------------
  always @* begin
    hit = 1'b1;
    for (i = 0; i < `SCMC_DIV_W; i = i + 1) begin
      if (i < sel && !count[i])
        hit = 1'b0;
    end
  end

  // Divide by 2^sel for sel 0..6
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 6'h00;
      tick <= 1'b0;
    end else if (run) begin
      count <= count + 6'h01;
      tick <= hit;
    end else begin
      // Count holds between edges so the ratio stays exact
      tick <= 1'b0;
    end
  end

endmodule // scmc_divider

// File: rtl/scmc_map.vh
// Constants for the system clock and operating mode control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH

// --------------------------------------------------------------
// Clock selection codes
// --------------------------------------------------------------
`define SCMC_SEL_W 3
`define SCMC_SEL_HS_DIV1 3'h0
`define SCMC_SEL_LS 3'h7
`define SCMC_DIV_W 6

// --------------------------------------------------------------
// Source select values and reset values
// --------------------------------------------------------------
`define SCMC_SRC_INT 1'h0
`define SCMC_SRC_EXT 1'h1
`define SCMC_KEEP_RESET 1'h0
`define SCMC_SEL_RESET 3'h0

// --------------------------------------------------------------
// Operating mode codes, one-hot
// --------------------------------------------------------------
`define SCMC_MODE_W 6
`define SCMC_MODE_FAST 6'h01
`define SCMC_MODE_SLOW 6'h02
`define SCMC_MODE_SLEEP 6'h04
`define SCMC_MODE_HALT_LS 6'h08
`define SCMC_MODE_HALT_BOTH 6'h10
`define SCMC_MODE_HALT_HS 6'h20

`endif

// File: verif/scmc_clock_mode_sva.sv
// Checker on the mode control ports of scmc_clock_mode.
// Assumes it is bound to that module and sees its ports only.
`timescale 1ns/1ns
`include "scmc_map.vh"

module scmc_clock_mode_sva (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Requests
  input wire hs_osc_enable,
  input wire watchdog_enable,
  input wire halt_req,
  input wire wake_req,
  // State
  input wire [2:0] sys_clk_select,
  input wire hs_osc_keep_in_halt,
  input wire ls_osc_keep_in_halt,
  input wire [5:0] mode,
  input wire cpu_run,
  input wire hs_osc_on,
  input wire ls_osc_on,
  input wire int_ls_rc_on,
  input wire sys_clk_on
);
  // Halt decodes the registered keep bits, not the write data
  wire [1:0] keeps = {hs_osc_keep_in_halt, ls_osc_keep_in_halt};
  wire go = halt_req && cpu_run;
  wire ls7 = sys_clk_select == 3'h7;
  wire [3:0] ons = {hs_osc_on, ls_osc_on, int_ls_rc_on, sys_clk_on};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_RESET: assert property ($rose(rst_n) |-> mode == `SCMC_MODE_FAST && keeps == 2'h0)
    else $error("reset state wrong");
  AST_SLEEP: assert property (go && keeps == 2'h0 |=> mode == `SCMC_MODE_SLEEP &&
    !cpu_run && {hs_osc_on, ls_osc_on, sys_clk_on} == 3'h0) else $error("sleep entry wrong");
  AST_HALT_LS: assert property (go && keeps == 2'h1 |=> mode == `SCMC_MODE_HALT_LS &&
    !cpu_run && ons == {3'h3, ls7}) else $error("halt_ls_only entry wrong");
  AST_HALT_BOTH: assert property (go && keeps == 2'h3 |=> mode == `SCMC_MODE_HALT_BOTH &&
    !cpu_run && ons == 4'hF) else $error("halt_both_osc entry wrong");
  AST_HALT_HS: assert property (go && keeps == 2'h2 |=> mode == `SCMC_MODE_HALT_HS &&
    !cpu_run && ons == {3'h5, !ls7}) else $error("halt_hs_only entry wrong");
  AST_SLEEP_RC: assert property (mode == `SCMC_MODE_SLEEP &&
    $past(mode) == `SCMC_MODE_SLEEP |-> int_ls_rc_on == $past(watchdog_enable))
    else $error("sleep rc level wrong");
  AST_FAST: assert property (mode == `SCMC_MODE_FAST |-> cpu_run && ons == 4'hF)
    else $error("fast mode clocks wrong");
  AST_SLOW: assert property (mode == `SCMC_MODE_SLOW |-> cpu_run &&
    hs_osc_on == $past(hs_osc_enable) && ons[2:0] == 3'h7) else $error("slow mode clocks wrong");
  AST_WAKE: assert property (wake_req && !cpu_run |=> cpu_run &&
    mode == (ls7 ? `SCMC_MODE_SLOW : `SCMC_MODE_FAST)) else $error("wake mode wrong");
endmodule // scmc_clock_mode_sva

bind scmc_clock_mode scmc_clock_mode_sva i_scmc_clock_mode_sva (.*);

// File: verif/scmc_cpu_model.sv
// CPU core model: issues control writes, halt and wake requests.
// Assumes the block samples every request on the rising edge of sys_clk.
`timescale 1ns/1ns

module scmc_cpu_model (
  // Clock
  input wire sys_clk,
  // Requests
  output wire ctrl_we,
  output wire [2:0] ctrl_sys_clk_select,
  output wire ctrl_hs_source_select,
  output wire ctrl_ls_source_select,
  output wire ctrl_hs_osc_keep_in_halt,
  output wire ctrl_ls_osc_keep_in_halt,
  output wire halt_req,
  output wire wake_req
);
  reg [2:0] strb = 3'h0;
  reg [6:0] data = 7'h0;

  assign {wake_req, halt_req, ctrl_we} = strb;
  assign {ctrl_sys_clk_select, ctrl_hs_source_select, ctrl_ls_source_select,
    ctrl_hs_osc_keep_in_halt, ctrl_ls_osc_keep_in_halt} = data;

  // ------------------
  // Request strobe
  // ------------------
  // Data flips to its inverse after the strobe so stale values cannot pass
  task automatic req(input [2:0] k, input [6:0] d);
    begin
      @(posedge sys_clk);
      strb <= k;
      data <= d;
      @(posedge sys_clk);
      strb <= 3'h0;
      data <= ~d;
    end
  endtask
endmodule // scmc_cpu_model

// File: verif/tb_top.sv
// Self-checking bench for the clock and mode control block.
// Assumes the CPU model makes requests; oscillators toggle here unless osc_run stops them.
`timescale 1ns/1ns
`include "scmc_map.vh"

module tb_top;
  reg sys_clk = 1'h0, rst_n = 1'h0, hs_osc_enable = 1'h0, watchdog_enable = 1'h0;
  reg ext_high_speed_crystal = 1'h0, int_high_speed_rc = 1'h0;
  reg ext_low_speed_crystal = 1'h0, int_low_speed_rc = 1'h0;
  reg [3:0] osc_run = 4'hF;
  wire ctrl_we, ctrl_hs_source_select, ctrl_ls_source_select, halt_req, wake_req;
  wire ctrl_hs_osc_keep_in_halt, ctrl_ls_osc_keep_in_halt, hs_source_select, ls_source_select;
  wire hs_osc_keep_in_halt, ls_osc_keep_in_halt, cpu_run, hs_osc_on, ls_osc_on, int_ls_rc_on;
  wire sys_clk_on, high_speed_clock, low_speed_clock, sys_clk_tick;
  wire [2:0] ctrl_sys_clk_select, sys_clk_select;
  wire [5:0] mode;
  wire [6:0] settings = {sys_clk_select, hs_source_select, ls_source_select,
    hs_osc_keep_in_halt, ls_osc_keep_in_halt};
  wire [10:0] state = {mode, cpu_run, hs_osc_on, ls_osc_on, int_ls_rc_on, sys_clk_on};
  reg [10:0] last, pe;
  reg [10:0] exp_q[$];
  reg [5:0] pm = `SCMC_MODE_FAST;
  reg [6:0] cur = 7'h0;
  integer mismatches = 0, n_compared = 0, seed = 71, i, r, a, b, c;
  integer n_hs = 0, n_ls = 0, n_tk = 0;

  scmc_clock_mode i_scmc_clock_mode (.*);
  scmc_cpu_model i_scmc_cpu_model (.*);

  initial forever #20 sys_clk = ~sys_clk;
  always #70 if (osc_run[0]) ext_high_speed_crystal = ~ext_high_speed_crystal;
  always #90 if (osc_run[1]) int_high_speed_rc = ~int_high_speed_rc;
  always #300 if (osc_run[2]) ext_low_speed_crystal = ~ext_low_speed_crystal;
  always #410 if (osc_run[3]) int_low_speed_rc = ~int_low_speed_rc;

  function automatic [10:0] exp_state(input [5:0] m);
    reg ls7;
    begin
      ls7 = cur[6:4] == 3'h7;
      case (m)
        `SCMC_MODE_FAST: exp_state = {m, 5'h1F};
        `SCMC_MODE_SLOW: exp_state = {m, 1'h1, hs_osc_enable, 3'h7};
        `SCMC_MODE_SLEEP: exp_state = {m, 3'h0, watchdog_enable, 1'h0};
        `SCMC_MODE_HALT_LS: exp_state = {m, 4'h3, ls7};
        `SCMC_MODE_HALT_BOTH: exp_state = {m, 5'h0F};
        default: exp_state = {m, 4'h5, !ls7};
      endcase
    end
  endfunction

  task automatic check(input [10:0] e, input [10:0] s, input string what);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", what, e, s);
      end
    end
  endtask

  // A note is queued only when the visible state is due to change
  task automatic note(input [5:0] m);
    reg [10:0] e;
    begin
      e = exp_state(m);
      if (e !== pe) exp_q.push_back(e);
      pe = e;
      pm = m;
    end
  endtask

  task automatic op(input [2:0] k, input [6:0] d);
    reg run;
    begin
      run = pm == `SCMC_MODE_FAST || pm == `SCMC_MODE_SLOW;
      i_scmc_cpu_model.req(k, d);
      if (k[0] && run) cur = d;
      #1 check({4'h0, cur}, {4'h0, settings}, "settings");
      if (k[1] && run) note(cur[1:0] == 2'h0 ? `SCMC_MODE_SLEEP : cur[1:0] == 2'h1 ?
        `SCMC_MODE_HALT_LS : cur[1:0] == 2'h3 ? `SCMC_MODE_HALT_BOTH : `SCMC_MODE_HALT_HS);
      else if ((k[0] && run) || (k[2] && !run)) note(cur[6:4] == 3'h7 ?
        `SCMC_MODE_SLOW : `SCMC_MODE_FAST);
    end
  endtask

  task results;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // ------------------
  // Monitors
  // ------------------
  always @(posedge sys_clk) begin
    if (!rst_n)
      last <= state;
    else if (state !== last) begin
      last <= state;
      if (exp_q.size() == 0)
        check(last, state, "unexpected change");
      else
        check(exp_q.pop_front(), state, "state");
    end
    if (rst_n) begin
      n_hs <= n_hs + high_speed_clock;
      n_ls <= n_ls + low_speed_clock;
      n_tk <= n_tk + sys_clk_tick;
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    results;
  end

  // ------------------
  // Stimulus
  // ------------------
  initial begin
    pe = exp_state(pm);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    #1 check(pe, state, "reset state");
    check(11'h0, {4'h0, settings}, "reset settings");
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      @(posedge sys_clk);
      hs_osc_enable <= r[5];
      watchdog_enable <= r[6];
      #1 note(pm);
      op(3'h1, {i[2] ? 3'h7 : r[2:0] % 3'h7, r[4:3], i[1:0]});
      op(3'h2, r[6:0]);
      op(3'h1, ~r[6:0]);
      op(3'h2, r[6:0]);
      op(3'h4, r[6:0]);
    end
    // Only one oscillator of each pair runs, so pulses show which one is used
    for (i = 0; i < 4; i = i + 1) begin
      op(3'h1, {3'h0, i[1], i[1], 2'h0});
      osc_run = (i[1] ~^ i[0]) ? 4'h5 : 4'hA;
      repeat (10) @(posedge sys_clk);
      a = n_hs;
      b = n_ls;
      c = n_tk;
      repeat (100) @(posedge sys_clk);
      check({8'h0, {3{i[0]}}}, {8'h0, n_hs > a, n_ls > b, n_tk > c}, "pulses");
    end
    // Each select against its source: hs edges over 2^sel, or ls edges
    osc_run = 4'h5;
    for (i = 0; i < 8; i = i + 1) begin
      op(3'h1, {i[2:0], 4'hC});
      repeat (10) @(posedge sys_clk);
      a = i == 7 ? n_ls : n_hs;
      c = n_tk;
      repeat (1000) @(posedge sys_clk);
      b = ((i == 7 ? n_ls : n_hs) - a) >> (i % 7);
      r = n_tk - c;
      check(11'h1, {10'h0, r >= b - 1 && r <= b + 1}, "divided tick");
    end
    repeat (5) @(posedge sys_clk);
    check(11'h0, 11'(exp_q.size()), "pending notes");
    results;
  end
endmodule // tb_top
